// >>> lcsfs_pkg.sv
package lcsfs_pkg;
   // ----------------------------------------
   // frame structure
   // ----------------------------------------
   localparam int FRAME_CLKS = 24;
   localparam logic [1:0] MUX_STATIC = 2'h0;
   localparam logic [1:0] MUX_TWO = 2'h1;
   localparam logic [1:0] MUX_THREE = 2'h2;
   localparam logic [1:0] MUX_FOUR = 2'h3;

   // ----------------------------------------
   // internal oscillator (nominal)
   // ----------------------------------------
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int OSC_SLOW_HZ = 1970;
   localparam int OSC_FAST_HZ = 2640;
   localparam int OSC_SLOW_MIN_HZ = 1440;
   localparam int OSC_SLOW_MAX_HZ = 2640;
   localparam int OSC_FAST_MIN_HZ = 1920;
   localparam int OSC_FAST_MAX_HZ = 3600;
   // half period in system cycles, so the clock pin toggles at 50 % duty
   localparam int OSC_SLOW_HALF = SYS_CLK_HZ / (2 * OSC_SLOW_HZ);
   localparam int OSC_FAST_HALF = SYS_CLK_HZ / (2 * OSC_FAST_HZ);

   // ----------------------------------------
   // sync line
   // ----------------------------------------
   localparam int SYNC_LOW_NS = 1000;
   localparam int SYNC_LOW_CLKS = (SYNC_LOW_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
endpackage : lcsfs_pkg

// >>> lcsfs_osc_div.sv
// ----------------------------------------
// internal oscillator: 50 % clock from system clock
// ----------------------------------------
module lcsfs_osc_div #(
   parameter int SLOW_HALF = lcsfs_pkg::OSC_SLOW_HALF,
   parameter int FAST_HALF = lcsfs_pkg::OSC_FAST_HALF
) (
   input wire logic clk, // system clock
   input wire logic sys_rst, // async reset, high
   input wire logic slowSel, // 1: slow rate, 0: fast rate
   output logic oscLevel, // oscillator level
   output logic oscRise // one-cycle pulse on rising edge
);
   logic [15:0] halfCnt;
   logic [15:0] halfLimit;

   assign halfLimit = slowSel ? 16'(SLOW_HALF - 1) : 16'(FAST_HALF - 1);

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         halfCnt <= 16'h0000;
         oscLevel <= 1'b0;
      end
      else if (halfCnt >= halfLimit)
      begin
         halfCnt <= 16'h0000;
         oscLevel <= ~oscLevel;
      end
      else
      begin
         halfCnt <= halfCnt + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         oscRise <= 1'b0;
      else
         oscRise <= (halfCnt >= halfLimit) && !oscLevel;
   end
endmodule : lcsfs_osc_div

// >>> lcsfs_frame_sync.sv
// Behaviour
// - frame lasts 24 periods of the active clock, internal or external.
// - select high: internal oscillator nominal 1970 Hz, driven out on clock pin.
// - select low: internal oscillator nominal 2640 Hz for the faster frame.
// - clock driven out has equal high and low times.
// - identity is slave address bit above three subaddress pins, index 0..15.
// - a slave runs its frame timing from the master's clock.
// - one device's backplanes may serve all; others give segments only.
// - after reset all devices are aligned without any sync activity.
// - sync recovers alignment lost to mode changes or noise, except in static mode.
// - sync pin is open-drain pull-down with pull-up, also monitored.
// - drive sync low at start of last active backplane phase only.
// - first device to assert sync sets the timing; others realign, except in static mode, where inLast is always set.
module lcsfs_frame_sync #(
   parameter int SLOW_HALF = lcsfs_pkg::OSC_SLOW_HALF,
   parameter int FAST_HALF = lcsfs_pkg::OSC_FAST_HALF,
   parameter int SYNC_LOW = lcsfs_pkg::SYNC_LOW_CLKS
) (
   input wire logic clk, // 100 MHz system clock
   input wire logic sys_rst, // async reset, high
   input wire logic frame_rate_select, // pin: 1 slow, 0 fast
   input wire logic isMaster, // 1: own oscillator drives clock pin
   input wire logic [1:0] muxMode, // backplane count minus one
   input wire logic subaddr_pin_bit0, // pin
   input wire logic subaddr_pin_bit1, // pin
   input wire logic subaddr_pin_bit2, // pin
   input wire logic slave_address_lsb, // slave address bit
   input wire logic clkPinIn, // clock pin input level
   output logic clkPinOut, // clock pin output level
   output logic clkPinOe_n, // clock pin enable, low drives
   input wire logic syncIn, // sync line level
   output logic syncOut, // sync output, always low
   output logic syncOe_n, // sync enable, low pulls down
   output logic [3:0] deviceIndex, // 4-bit device index
   output logic [3:0] backplanePhase, // one-hot active backplane
   output logic [1:0] phaseIndex, // active backplane number
   output logic frameStart, // one-cycle pulse at frame start
   output logic [4:0] frameCount // position in frame, 0..23
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] selMeta;
   logic [1:0] clkMeta;
   logic [1:0] syncMeta;
   logic [2:0] addrMeta0;
   logic [2:0] addrMeta1;
   logic saMeta0;
   logic saMeta1;
   logic selS;
   logic clkS;
   logic syncS;
   logic clkPrev;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         selMeta <= 2'h3;
         clkMeta <= 2'h0;
         syncMeta <= 2'h3;
         addrMeta0 <= 3'h0;
         addrMeta1 <= 3'h0;
         saMeta0 <= 1'b0;
         saMeta1 <= 1'b0;
      end
      else
      begin
         selMeta <= {selMeta[0], frame_rate_select};
         clkMeta <= {clkMeta[0], clkPinIn};
         syncMeta <= {syncMeta[0], syncIn};
         addrMeta0 <= {subaddr_pin_bit2, subaddr_pin_bit1, subaddr_pin_bit0};
         addrMeta1 <= addrMeta0;
         saMeta0 <= slave_address_lsb;
         saMeta1 <= saMeta0;
      end
   end

   assign selS = selMeta[1];
   assign clkS = clkMeta[1];
   assign syncS = syncMeta[1];

   // ----------------------------------------
   // identity
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         deviceIndex <= 4'h0;
      else
         deviceIndex <= {saMeta1, addrMeta1};
   end

   // ----------------------------------------
   // active clock selection
   // ----------------------------------------
   logic oscLevel;
   logic oscRise;
   logic extRise;
   logic tick;

   lcsfs_osc_div #(
      .SLOW_HALF(SLOW_HALF),
      .FAST_HALF(FAST_HALF)
   ) u_osc (
      .clk(clk),
      .sys_rst(sys_rst),
      .slowSel(selS),
      .oscLevel(oscLevel),
      .oscRise(oscRise)
   );

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         clkPrev <= 1'b0;
      else
         clkPrev <= clkS;
   end

   assign extRise = clkS && !clkPrev;
   // master counts its own oscillator, a slave the master's clock
   assign tick = isMaster ? oscRise : extRise;

   // ----------------------------------------
   // clock pin drive
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         clkPinOut <= 1'b0;
      else
         clkPinOut <= oscLevel;
   end

   // only the master drives the pin; a slave listens for its clock
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         clkPinOe_n <= 1'b1;
      else
         clkPinOe_n <= !isMaster;
   end

   // ----------------------------------------
   // frame position
   // ----------------------------------------
   // all devices reset to count 0, so a cascade released together is
   // aligned without touching the sync line
   logic [4:0] next_frameCount;
   logic [4:0] phaseLen;
   logic [4:0] lastStart;
   logic inLast;
   logic syncFall;
   logic syncPrev;
   logic ownAssert;

   function automatic logic [4:0] phase_len(input logic [1:0] mode);
      case (mode)
         lcsfs_pkg::MUX_STATIC: phase_len = 5'(lcsfs_pkg::FRAME_CLKS / 1);
         lcsfs_pkg::MUX_TWO: phase_len = 5'(lcsfs_pkg::FRAME_CLKS / 2);
         lcsfs_pkg::MUX_THREE: phase_len = 5'(lcsfs_pkg::FRAME_CLKS / 3);
         default: phase_len = 5'(lcsfs_pkg::FRAME_CLKS / 4);
      endcase
   endfunction : phase_len

   assign phaseLen = phase_len(muxMode);
   assign lastStart = 5'(lcsfs_pkg::FRAME_CLKS) - phaseLen;
   assign inLast = frameCount >= lastStart;

   // ----------------------------------------
   // sync line sense
   // ----------------------------------------

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         syncPrev <= 1'b1;
      else
         syncPrev <= syncS;
   end

   assign syncFall = !syncS && syncPrev;

   // ----------------------------------------
   // frame counter
   // ----------------------------------------

   always_comb
   begin
      next_frameCount = frameCount;
      if (syncFall && !ownAssert && !inLast)
         next_frameCount = lastStart;
      else if (tick)
      begin
         if (frameCount == 5'(lcsfs_pkg::FRAME_CLKS - 1))
            next_frameCount = 5'h00;
         else
            next_frameCount = frameCount + 5'h01;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         frameCount <= 5'h00;
      else
         frameCount <= next_frameCount;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         frameStart <= 1'b0;
      else
         frameStart <= tick && (frameCount == 5'(lcsfs_pkg::FRAME_CLKS - 1));
   end

   // ----------------------------------------
   // backplane phase
   // ----------------------------------------
   logic [1:0] next_phase;

   always_comb
   begin
      next_phase = 2'h0;
      // products reach 3 x 24, so compare at seven bits
      for (int i = 1; i < 4; i++)
      begin
         if (7'(next_frameCount) >= 7'(i) * 7'(phaseLen))
            next_phase = 2'(i);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         phaseIndex <= 2'h0;
         backplanePhase <= 4'h1;
      end
      else
      begin
         phaseIndex <= next_phase;
         // backplanes are always produced; unused ones are left open outside
         backplanePhase <= 4'h1 << next_phase;
      end
   end

   // ----------------------------------------
   // sync line drive
   // ----------------------------------------
   // pulse held for at least the minimum low time, then released so the
   // pull-up restores the line; monitoring continues meanwhile
   logic [7:0] lowCnt;
   logic enterLast;

   assign enterLast = (next_frameCount == lastStart) && (frameCount != lastStart);

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         lowCnt <= 8'h00;
      else if (enterLast)
         lowCnt <= 8'(SYNC_LOW);
      else if (lowCnt != 8'h00)
         lowCnt <= lowCnt - 8'h01;
   end

   // own pulse, plus pipeline delay of the synchroniser, masks self-trigger
   logic [2:0] ownHist;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         ownHist <= 3'h0;
      else
         ownHist <= {ownHist[1:0], lowCnt != 8'h00};
   end

   assign ownAssert = (lowCnt != 8'h00) || (ownHist != 3'h0);

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         syncOut <= 1'b0;
      else
         syncOut <= 1'b0;
   end

   // open drain: only the enable moves, the level stays low
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         syncOe_n <= 1'b1;
      else
         syncOe_n <= !(enterLast || (lowCnt > 8'h01));
   end
endmodule : lcsfs_frame_sync

// >>> lcsfs_peer.sv
// ----
// another cascaded device: sync puller and master clock
// ----
module lcsfs_peer #(
   parameter int HALF = 5
) (
   input wire logic clk, // system clock
   input wire logic sys_rst, // async reset, high
   input wire logic pullReq, // hold sync low
   input wire logic runClk, // act as clock master
   output logic syncOe_n, // low pulls sync down
   output logic extClk // clock to slaves
);
   int cnt;
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         syncOe_n <= 1'b1;
      else
         syncOe_n <= !pullReq;
   // backplanes of this device stay unused, segments only
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
      begin
         cnt <= 0;
         extClk <= 1'b0;
      end
      else if (!runClk)
         extClk <= 1'b0;
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         extClk <= !extClk;
      end
      else
         cnt <= cnt + 1;
endmodule : lcsfs_peer

// >>> lcsfs_checker_sva.sv
module lcsfs_checker #(
   parameter int SYNC_LOW = 4
) (
   input wire logic clk, // system clock
   input wire logic sys_rst, // async reset
   input wire logic isMaster, // master select
   input wire logic [1:0] muxMode, // drive mode
   input wire logic subaddr_pin_bit0, // pin
   input wire logic subaddr_pin_bit1, // pin
   input wire logic subaddr_pin_bit2, // pin
   input wire logic slave_address_lsb, // address bit
   input wire logic clkPinOe_n, // clock pin enable
   input wire logic syncOut, // sync level
   input wire logic syncOe_n, // sync enable
   input wire logic [3:0] deviceIndex, // index
   input wire logic [3:0] backplanePhase, // phase
   input wire logic [1:0] phaseIndex, // phase number
   input wire logic frameStart, // frame pulse
   input wire logic [4:0] frameCount // position
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   int lowRun;
   wire logic [3:0] pins = {slave_address_lsb, subaddr_pin_bit2, subaddr_pin_bit1, subaddr_pin_bit0};
   sequence heldMaster;
      isMaster[*3];
   endsequence
   sequence heldSlave;
      !isMaster[*3];
   endsequence
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         lowRun <= 0;
      else
         lowRun <= syncOe_n ? 0 : lowRun + 1;
   a_sync_phase: assert property ($fell(syncOe_n) && $stable(muxMode) |-> frameCount == 24 - 24 / (muxMode + 1))
      else $error("sync pulled outside last phase start");
   a_sync_len: assert property ($rose(syncOe_n) |-> lowRun == SYNC_LOW)
      else $error("sync pulse length wrong");
   a_sync_low: assert property (syncOut == 1'b0)
      else $error("sync drives high");
   a_frame_wrap: assert property (frameStart |-> frameCount == 5'h0)
      else $error("frame start off position zero");
   a_count_range: assert property (frameCount < 5'h18)
      else $error("frame position beyond 23");
   a_phase_hot: assert property (backplanePhase == 4'h1 << phaseIndex)
      else $error("backplane phase not one-hot");
   a_master_drive: assert property (heldMaster |-> !clkPinOe_n)
      else $error("master not driving clock pin");
   a_slave_listen: assert property (heldSlave |-> clkPinOe_n)
      else $error("slave drives clock pin");
   a_index_map: assert property ($stable(pins)[*4] |-> deviceIndex == pins)
      else $error("device index mismatch");
   a_phase_last: assert property ($fell(syncOe_n) && $stable(muxMode) |-> phaseIndex == muxMode)
      else $error("sync pulled outside last backplane");
endmodule : lcsfs_checker
bind lcsfs_frame_sync lcsfs_checker #(.SYNC_LOW(SYNC_LOW)) lcsfs_checker_inst (.clk(clk), .sys_rst(sys_rst),
   .isMaster(isMaster), .muxMode(muxMode), .subaddr_pin_bit0(subaddr_pin_bit0), .subaddr_pin_bit1(subaddr_pin_bit1),
   .subaddr_pin_bit2(subaddr_pin_bit2), .slave_address_lsb(slave_address_lsb), .clkPinOe_n(clkPinOe_n),
   .syncOut(syncOut), .syncOe_n(syncOe_n), .deviceIndex(deviceIndex), .backplanePhase(backplanePhase),
   .phaseIndex(phaseIndex), .frameStart(frameStart), .frameCount(frameCount));

// >>> lcd_cascade_frame_sync_test.sv
module lcd_cascade_frame_sync_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, sys_rst = 1, fsel = 1, isMaster = 1, pullReq = 0, runClk = 0;
   logic [1:0] muxMode = 2'h3;
   logic [3:0] addr = 4'h0;
   logic clkPinOut, clkPinOe_n, syncOut, syncOe_n, peerOe_n, peerClk, frameStart;
   logic [3:0] deviceIndex, backplanePhase;
   logic [1:0] phaseIndex;
   logic [4:0] frameCount;
   int fails = 0, total_checks = 0;
   // ----
   // wires: sync has a pull-up, clock pin from whoever drives it
   // ----
   wire logic syncLine = syncOe_n & peerOe_n;
   wire logic clkPin = clkPinOe_n ? peerClk : clkPinOut;
   always #5 clk = ~clk;
   lcsfs_frame_sync #(.SLOW_HALF(4), .FAST_HALF(3), .SYNC_LOW(4)) lcsfs_frame_sync_inst (.clk(clk),
      .sys_rst(sys_rst), .frame_rate_select(fsel), .isMaster(isMaster), .muxMode(muxMode),
      .subaddr_pin_bit0(addr[0]), .subaddr_pin_bit1(addr[1]), .subaddr_pin_bit2(addr[2]),
      .slave_address_lsb(addr[3]), .clkPinIn(clkPin), .clkPinOut(clkPinOut), .clkPinOe_n(clkPinOe_n),
      .syncIn(syncLine), .syncOut(syncOut), .syncOe_n(syncOe_n), .deviceIndex(deviceIndex),
      .backplanePhase(backplanePhase), .phaseIndex(phaseIndex), .frameStart(frameStart), .frameCount(frameCount));
   lcsfs_peer #(.HALF(5)) lcsfs_peer_inst (.clk(clk), .sys_rst(sys_rst), .pullReq(pullReq), .runClk(runClk),
      .syncOe_n(peerOe_n), .extClk(peerClk));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic give_up(input int n, input int lim);
      if (n >= lim)
      begin
         fails++;
         $display("BAD %0t wait limit reached", $time);
         wrap_up();
      end
   endtask : give_up
   task automatic wait_start(output int n);
      @(posedge clk);
      for (n = 1; frameStart !== 1'b1 && n < 999; n++) @(posedge clk);
      give_up(n, 999);
   endtask : wait_start
   task automatic t_rate(input logic sel, input int frame, input int half);
      int n;
      @(posedge clk);
      fsel <= sel;
      repeat (3) wait_start(n);
      check(n, frame);
      check(clkPinOe_n, 0);
      for (n = 0; clkPinOut !== 1'b1 && n < 99; n++) @(posedge clk);
      give_up(n, 99);
      for (n = 0; clkPinOut === 1'b1 && n < 99; n++) @(posedge clk);
      give_up(n, 99);
      check(n, half);
   endtask : t_rate
   task automatic t_index;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk);
         addr <= 4'(i);
         repeat (5) @(posedge clk);
         check(deviceIndex, i);
      end
   endtask : t_index
   task automatic t_sync;
      int n;
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk);
         muxMode <= 2'(m);
         repeat (2) wait_start(n);
         for (n = 0; syncOe_n !== 1'b0 && n < 999; n++) @(negedge clk);
         give_up(n, 999);
         check(frameCount, 24 - 24 / (m + 1));
         check(phaseIndex, m);
         check(backplanePhase, 16'h1 << m);
      end
   endtask : t_sync
   task automatic t_realign;
      int n;
      wait_start(n);
      repeat (20) @(posedge clk);
      pullReq <= 1'b1;
      for (n = 0; frameCount !== 5'h12 && n < 12; n++) @(negedge clk);
      give_up(n, 12);
      check(frameCount, 18);
      check(phaseIndex, 3);
      check(syncOe_n, 0);
      @(posedge clk);
      pullReq <= 1'b0;
   endtask : t_realign
   task automatic t_slave;
      int n;
      @(posedge clk);
      isMaster <= 1'b0;
      runClk <= 1'b1;
      repeat (3) wait_start(n);
      check(n, 240);
      check(clkPinOe_n, 1);
   endtask : t_slave
   initial
   begin
      repeat (7) @(posedge clk);
      check({syncOe_n, backplanePhase, frameCount}, 16'h0220);
      @(posedge clk);
      sys_rst <= 1'b0;
      t_index();
      t_rate(1'b1, 192, 4);
      t_rate(1'b0, 144, 3);
      t_sync();
      t_realign();
      t_slave();
      wrap_up();
   end
endmodule : lcd_cascade_frame_sync_test
